// File: common/tw_pkg.sv
// Shared constants for the two-wire host port, boot loader and host master
package tw_pkg;
   // Slave addresses chosen by the address select pin
   localparam logic [6:0]  SLAVE_ADDR_LO = 7'h5C;
   localparam logic [6:0]  SLAVE_ADDR_HI = 7'h5D;
   // Device register offsets
   localparam logic [7:0]  REG_INT_CFG    = 8'h30;
   localparam logic [7:0]  REG_INT_STATUS = 8'h31;
   localparam logic [7:0]  REG_BOOT_MEMORY_DEVICE_ADDRESS = 8'h51;
   localparam logic [7:0]  REG_BOOT_CTRL  = 8'h52;
   localparam logic [7:0]  REG_BOOT_STAT  = 8'h53;
   localparam logic [7:0]  REG_BOOT_LEN   = 8'h54;
   localparam logic [7:0]  REG_PM_DATA    = 8'h55;
   // Device field positions and reset values
   localparam int          INT_POL_BIT    = 0;
   localparam int          INT_TOUCH_BIT  = 0;
   localparam int          BOOT_SRC_BIT   = 0;
   localparam int          BOOT_GO_BIT    = 1;
   localparam logic [7:0]  EE_ADDR_RST    = 8'h50;
   localparam int          PM_AW          = 12;
   // Host master register byte offsets on Avalon-MM
   localparam logic [7:0]  AV_CMD     = 8'h00;
   localparam logic [7:0]  AV_REGADDR = 8'h04;
   localparam logic [7:0]  AV_WDATA   = 8'h08;
   localparam logic [7:0]  AV_STATUS  = 8'h0C;
   localparam logic [7:0]  AV_SLAVE   = 8'h10;
   localparam int          CMD_GO_BIT   = 0;
   localparam int          CMD_READ_BIT = 1;
   // Serial timing, quarter bit periods
   localparam int          CLK_NS      = 100;
   localparam int          EE_QTR_NS   = 800;
   localparam int          HOST_QTR_NS = 650;
   localparam logic [3:0]  EE_QTR_CYC   = 4'((EE_QTR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  HOST_QTR_CYC = 4'((HOST_QTR_NS + CLK_NS - 1) / CLK_NS);
endpackage : tw_pkg

// File: common/tw_if.sv
// Two-wire link between host master and device slave
`timescale 1ns/1ps
interface tw_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Open-drain wired AND with pull-ups
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host_mp (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
   modport dev_mp (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : tw_if

// File: verilog/tw_dev.sv
// Device end: two-wire register slave, boot loader master and interrupt pin
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tw_dev (
   input  logic                     clock,
   input  logic                     reset_n,
   tw_if.dev_mp                     bus,
   input  logic                     address_select_pin,
   input  logic                     host_port_select_pin,
   input  logic                     touch_event,
   output logic                     int_out,
   output logic                     ee_scl,
   input  logic                     ee_sda_in,
   output logic                     ee_sda_out,
   output logic                     ee_sda_oe,
   output logic                     pm_we,
   output logic [tw_pkg::PM_AW-1:0] pm_addr,
   output logic [7:0]               pm_data
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RX   = 5'b00010,
      S_ACK  = 5'b00100,
      S_TX   = 5'b01000,
      S_RACK = 5'b10000
   } tw_dst_e;

   typedef enum logic [4:0] {
      L_IDLE  = 5'b00001,
      L_START = 5'b00010,
      L_TX    = 5'b00100,
      L_RX    = 5'b01000,
      L_STOP  = 5'b10000
   } tw_lst_e;

   typedef struct packed {
      logic [255:0][7:0]       regs;
      logic [7:0]              int_st;
      logic                    int_q;
      logic                    scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
      logic                    asel_m, asel_s, psel_m, psel_s, eda_m, eda_s;
      tw_dst_e                 st;
      logic [1:0]              kind;
      logic [3:0]              cnt;
      logic [7:0]              sh, tx, ptr;
      logic                    dir, sda_oe;
      tw_lst_e                 lst;
      logic [2:0]              seq;
      logic [1:0]              ph;
      logic [3:0]              qc, bi;
      logic [7:0]              esh, bcnt;
      logic                    ecl, eoe, busy, done, nack, pm_we;
      logic [tw_pkg::PM_AW-1:0] pm_addr, pm_next;
      logic [7:0]              pm_data;
   } tw_dev_s;

   tw_dev_s    q;
   tw_dev_s    n;
   logic       rise, fall, start, stop;
   logic [6:0] own_addr;
   logic [7:0] rd_val;
   logic       last;
   logic       load_tx;
   logic       done_op;
   logic       v1, v3;
   logic [2:0] sn;

   // Bus events from synchronised copies only
   assign rise  = q.scl_s & ~q.scl_p;
   assign fall  = ~q.scl_s & q.scl_p;
   assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign own_addr = q.asel_s ? tw_pkg::SLAVE_ADDR_HI : tw_pkg::SLAVE_ADDR_LO;
   assign last = (q.bcnt == q.regs[tw_pkg::REG_BOOT_LEN]);
   // Read value: hardware status registers override the array
   assign rd_val = (q.ptr == tw_pkg::REG_INT_STATUS) ? q.int_st :
                   (q.ptr == tw_pkg::REG_BOOT_STAT) ? {5'h00, q.nack, q.done, q.busy} :
                   q.regs[q.ptr];

   // Next state of slave, interrupt and loader
   always_comb begin
      n = q;
      load_tx = 1'b0;
      done_op = 1'b1;
      sn = 3'h0;
      n.pm_we = 1'b0;
      n.scl_m = bus.scl;
      n.scl_s = q.scl_m;
      n.scl_p = q.scl_s;
      n.sda_m = bus.sda;
      n.sda_s = q.sda_m;
      n.sda_p = q.sda_s;
      n.asel_m = address_select_pin;
      n.asel_s = q.asel_m;
      n.psel_m = host_port_select_pin;
      n.psel_s = q.psel_m;
      n.eda_m = ee_sda_in;
      n.eda_s = q.eda_m;
      // Slave link, idle while the SPI port is selected
      if (!q.psel_s) begin
         n.st = S_IDLE;
         n.sda_oe = 1'b0;
      end else if (start) begin
         n.st = S_RX;
         n.kind = 2'd0;
         n.cnt = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st = S_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            S_IDLE: begin
            end
            S_RX: begin
               if (rise && !q.cnt[3]) begin
                  n.sh = {q.sh[6:0], q.sda_s};
                  n.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt[3]) begin
                  n.cnt = 4'h0;
                  n.st = S_ACK;
                  n.sda_oe = 1'b1;
                  if (q.kind == 2'd0) begin
                     n.dir = q.sh[0];
                     if (q.sh[7:1] != own_addr) begin
                        n.st = S_IDLE;
                        n.sda_oe = 1'b0;
                     end
                  end else if (q.kind == 2'd1) begin
                     n.ptr = q.sh;
                  end else begin
                     n.regs[q.ptr] = q.sh;
                     n.ptr = q.ptr + 8'h01;
                     if (q.ptr == tw_pkg::REG_PM_DATA) begin
                        n.pm_we = 1'b1;
                        n.pm_data = q.sh;
                        n.pm_addr = q.pm_next;
                        n.pm_next = q.pm_next + 1'b1;
                     end
                     if (q.ptr == tw_pkg::REG_BOOT_CTRL) begin
                        n.pm_next = '0;
                        if (q.sh[tw_pkg::BOOT_GO_BIT] && q.sh[tw_pkg::BOOT_SRC_BIT]
                            && q.lst == L_IDLE) begin
                           n.lst = L_START;
                           n.seq = 3'h0;
                           n.ph = 2'd0;
                           n.qc = 4'h0;
                           n.bi = 4'h0;
                           n.bcnt = 8'h00;
                           n.busy = 1'b1;
                           n.done = 1'b0;
                           n.nack = 1'b0;
                        end
                     end
                  end
               end
            end
            S_ACK: begin
               if (fall) begin
                  if (q.dir && q.kind == 2'd0) begin
                     load_tx = 1'b1;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st = S_RX;
                     n.kind = (q.kind == 2'd2) ? 2'd2 : q.kind + 2'd1;
                  end
               end
            end
            S_TX: begin
               if (fall) begin
                  if (q.cnt == 4'h7) begin
                     n.sda_oe = 1'b0;
                     n.st = S_RACK;
                  end else begin
                     n.tx = {q.tx[6:0], 1'b0};
                     n.sda_oe = ~q.tx[6];
                     n.cnt = q.cnt + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (rise) begin
                  n.sh[0] = q.sda_s;
               end else if (fall) begin
                  if (!q.sh[0]) begin
                     load_tx = 1'b1;
                  end else begin
                     n.st = S_IDLE;
                  end
               end
            end
         endcase
      end
      // Read byte load; interrupt status cleared by reading it
      if (load_tx) begin
         n.tx = rd_val;
         n.sda_oe = ~rd_val[7];
         n.cnt = 4'h0;
         n.st = S_TX;
         n.ptr = q.ptr + 8'h01;
         if (q.ptr == tw_pkg::REG_INT_STATUS) begin
            n.int_st = 8'h00;
         end
      end
      // Touch set wins over read clear
      if (touch_event) begin
         n.int_st[tw_pkg::INT_TOUCH_BIT] = 1'b1;
      end
      n.int_q = q.regs[tw_pkg::REG_INT_CFG][tw_pkg::INT_POL_BIT] ? (|n.int_st) : ~(|n.int_st);
      // Loader bit values for phases 1 and 3
      v1 = 1'b1;
      v3 = 1'b1;
      unique case (q.lst)
         L_IDLE: begin
         end
         L_START: begin
            v3 = 1'b0;
         end
         L_STOP: begin
            v1 = 1'b0;
         end
         L_TX: begin
            v1 = q.bi[3] | q.esh[7];
            v3 = v1;
         end
         L_RX: begin
            v1 = q.bi[3] ? last : 1'b1;
            v3 = v1;
         end
      endcase
      // Loader quarter-bit engine, address byte writes then data byte reads
      if (q.lst != L_IDLE) begin
         if (q.qc != tw_pkg::EE_QTR_CYC - 4'h1) begin
            n.qc = q.qc + 4'h1;
         end else begin
            n.qc = 4'h0;
            n.ph = q.ph + 2'd1;
            // Start keeps an idle-high clock high, stop leaves it high
            if (q.lst == L_START && q.ph == 2'd0) begin
               n.ecl = q.ecl;
            end else if (q.lst == L_STOP && q.ph == 2'd3) begin
               n.ecl = 1'b1;
            end else begin
               n.ecl = q.ph[0] ^ q.ph[1];
            end
            if (q.ph == 2'd0) begin
               n.eoe = ~v1;
            end
            if (q.ph == 2'd2) begin
               n.eoe = ~v3;
            end
            if (q.ph == 2'd3) begin
               if (q.lst == L_TX) begin
                  if (!q.bi[3]) begin
                     n.esh = {q.esh[6:0], 1'b0};
                     n.bi = q.bi + 4'h1;
                     done_op = 1'b0;
                  end else if (q.eda_s) begin
                     n.nack = 1'b1;
                     n.seq = 3'h5;
                  end
               end else if (q.lst == L_RX) begin
                  if (!q.bi[3]) begin
                     n.esh = {q.esh[6:0], q.eda_s};
                     n.bi = q.bi + 4'h1;
                     done_op = 1'b0;
                  end else begin
                     n.pm_we = 1'b1;
                     n.pm_data = q.esh;
                     n.pm_addr = q.pm_next;
                     n.pm_next = q.pm_next + 1'b1;
                     n.bcnt = q.bcnt + 8'h01;
                     done_op = last;
                  end
               end
               if (q.bi[3]) begin
                  n.bi = 4'h0;
               end
               if (done_op) begin
                  sn = n.seq + 3'h1;
                  n.seq = sn;
                  case (sn)
                     3'h1: begin
                        n.lst = L_TX;
                        n.esh = {q.regs[tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS][6:0], 1'b0};
                     end
                     3'h2: begin
                        n.lst = L_TX;
                        n.esh = 8'h00;
                     end
                     3'h3: n.lst = L_START;
                     3'h4: begin
                        n.lst = L_TX;
                        n.esh = {q.regs[tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS][6:0], 1'b1};
                     end
                     3'h5: n.lst = L_RX;
                     3'h6: n.lst = L_STOP;
                     default: begin
                        n.lst = L_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                     end
                  endcase
               end
            end
         end
      end
   end

   // State register on the internal system clock
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         q <= '0;
         q.regs[tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS] <= tw_pkg::EE_ADDR_RST;
         q.st <= S_IDLE;
         q.lst <= L_IDLE;
         {q.scl_m, q.scl_s, q.scl_p, q.sda_m, q.sda_s, q.sda_p, q.eda_m, q.eda_s} <= 8'hFF;
         q.int_q <= 1'b1;
         q.ecl <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = q.sda_oe;
   assign int_out        = q.int_q;
   assign ee_scl         = q.ecl;
   assign ee_sda_out     = 1'b0;
   assign ee_sda_oe      = q.eoe;
   assign pm_we          = q.pm_we;
   assign pm_addr        = q.pm_addr;
   assign pm_data        = q.pm_data;
endmodule : tw_dev

// File: verilog/tw_host.sv
// Host end: Avalon-MM controlled two-wire master for register access
`timescale 1ns/1ps
module tw_host (
   input  logic        clock,
   input  logic        reset_n,
   tw_if.host_mp       bus,
   input  logic [7:0]  avs_address,
   input  logic        avs_read,
   input  logic        avs_write,
   input  logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic        avs_waitrequest
);
   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_START = 5'b00010,
      H_TX    = 5'b00100,
      H_RX    = 5'b01000,
      H_STOP  = 5'b10000
   } tw_hst_e;

   typedef struct packed {
      logic        wait_q;
      logic [31:0] rdata;
      logic [7:0]  regaddr, wdata, rx;
      logic [6:0]  slave;
      logic        rd, busy, nack;
      logic        sda_m, sda_s;
      tw_hst_e     st;
      logic [2:0]  seq;
      logic [1:0]  ph;
      logic [3:0]  qc, bi;
      logic [7:0]  sh;
      logic        scl_lvl, sda_oe;
   } tw_host_s;

   tw_host_s   q;
   tw_host_s   n;
   logic       req;
   logic       v1, v3;
   logic       done_op;
   logic [2:0] sn;

   assign req = avs_read | avs_write;

   // Next state of bus slave and link master
   always_comb begin
      n = q;
      done_op = 1'b1;
      sn = 3'h0;
      n.sda_m = bus.sda;
      n.sda_s = q.sda_m;
      // Avalon: one wait cycle, then the access completes
      if (req && q.wait_q) begin
         n.wait_q = 1'b0;
         case (avs_address)
            tw_pkg::AV_CMD:     n.rdata = {30'h0, q.rd, 1'b0};
            tw_pkg::AV_REGADDR: n.rdata = {24'h0, q.regaddr};
            tw_pkg::AV_WDATA:   n.rdata = {24'h0, q.wdata};
            tw_pkg::AV_STATUS:  n.rdata = {16'h0, q.rx, 6'h0, q.nack, q.busy};
            tw_pkg::AV_SLAVE:   n.rdata = {25'h0, q.slave};
            default:            n.rdata = 32'h0;
         endcase
      end else if (req) begin
         n.wait_q = 1'b1;
         if (avs_write) begin
            case (avs_address)
               tw_pkg::AV_REGADDR: n.regaddr = avs_writedata[7:0];
               tw_pkg::AV_WDATA:   n.wdata = avs_writedata[7:0];
               tw_pkg::AV_SLAVE:   n.slave = avs_writedata[6:0];
               tw_pkg::AV_CMD: begin
                  if (avs_writedata[tw_pkg::CMD_GO_BIT] && !q.busy) begin
                     n.rd = avs_writedata[tw_pkg::CMD_READ_BIT];
                     n.busy = 1'b1;
                     n.nack = 1'b0;
                     n.st = H_START;
                     n.seq = 3'h0;
                     n.ph = 2'd0;
                     n.qc = 4'h0;
                     n.bi = 4'h0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Bit values for phases 1 and 3
      v1 = 1'b1;
      v3 = 1'b1;
      unique case (q.st)
         H_IDLE: begin
         end
         H_START: v3 = 1'b0;
         H_STOP: v1 = 1'b0;
         H_TX: begin
            v1 = q.bi[3] | q.sh[7];
            v3 = v1;
         end
         H_RX: begin
            v1 = 1'b1;
            v3 = 1'b1;
         end
      endcase
      // Quarter-bit engine, makes the link clock
      if (q.st != H_IDLE) begin
         if (q.qc != tw_pkg::HOST_QTR_CYC - 4'h1) begin
            n.qc = q.qc + 4'h1;
         end else begin
            n.qc = 4'h0;
            n.ph = q.ph + 2'd1;
            // Start keeps an idle-high clock high, stop leaves it high
            if (q.st == H_START && q.ph == 2'd0) begin
               n.scl_lvl = q.scl_lvl;
            end else if (q.st == H_STOP && q.ph == 2'd3) begin
               n.scl_lvl = 1'b1;
            end else begin
               n.scl_lvl = q.ph[0] ^ q.ph[1];
            end
            if (q.ph == 2'd0) begin
               n.sda_oe = ~v1;
            end
            if (q.ph == 2'd2) begin
               n.sda_oe = ~v3;
            end
            if (q.ph == 2'd3) begin
               if (q.st == H_TX) begin
                  if (!q.bi[3]) begin
                     n.sh = {q.sh[6:0], 1'b0};
                     n.bi = q.bi + 4'h1;
                     done_op = 1'b0;
                  end else if (q.sda_s) begin
                     n.nack = 1'b1;
                     n.seq = q.rd ? 3'h5 : 3'h3;
                  end
               end else if (q.st == H_RX) begin
                  if (!q.bi[3]) begin
                     n.sh = {q.sh[6:0], q.sda_s};
                     n.bi = q.bi + 4'h1;
                     done_op = 1'b0;
                  end else begin
                     n.rx = q.sh;
                  end
               end
               if (q.bi[3]) begin
                  n.bi = 4'h0;
               end
               if (done_op) begin
                  sn = n.seq + 3'h1;
                  n.seq = sn;
                  case (sn)
                     3'h1: begin
                        n.st = H_TX;
                        n.sh = {q.slave, 1'b0};
                     end
                     3'h2: begin
                        n.st = H_TX;
                        n.sh = q.regaddr;
                     end
                     3'h3: begin
                        n.st = q.rd ? H_START : H_TX;
                        n.sh = q.wdata;
                     end
                     3'h4: begin
                        n.st = q.rd ? H_TX : H_STOP;
                        n.sh = {q.slave, 1'b1};
                     end
                     3'h5: n.st = q.rd ? H_RX : H_IDLE;
                     3'h6: n.st = H_STOP;
                     default: n.st = H_IDLE;
                  endcase
                  if (n.st == H_IDLE) begin
                     n.busy = 1'b0;
                  end
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         q <= '0;
         q.wait_q <= 1'b1;
         q.slave <= tw_pkg::SLAVE_ADDR_LO;
         q.st <= H_IDLE;
         q.scl_lvl <= 1'b1;
         {q.sda_m, q.sda_s} <= 2'h3;
      end else begin
         q <= n;
      end
   end

   assign bus.host_scl_o  = 1'b0;
   assign bus.host_scl_oe = ~q.scl_lvl;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = q.sda_oe;
   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.wait_q;
endmodule : tw_host

// File: tb/tw_link_monitor.sv
// Checker of the two-wire link between the host and device ends
`timescale 1ns/1ps
module tw_link_monitor (
   input logic clock,
   input logic reset_n,
   input logic host_scl_oe,
   input logic host_sda_oe,
   input logic dev_sda_oe,
   input logic scl,
   input logic sda
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Runs of one level of the link clock
   sequence low_run; (!scl) [*8]; endsequence
   sequence high_run; scl [*8]; endsequence
   // Wire rules
   rst_free_a: assert property ($rose(reset_n) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
      else $error("link not released after reset");
   ack_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved with scl high");
   // Host lets go of sda within four clock cycles of the device taking it
   no_clash_a: assert property (dev_sda_oe && $past(dev_sda_oe, 4) |-> !host_sda_oe)
      else $error("host still pulls sda under device drive");
   ack_launch_a: assert property ($rose(dev_sda_oe) |-> !$past(scl, 2) ##0 low_run)
      else $error("device drive not in scl low");
   ack_drop_a: assert property ($fell(dev_sda_oe) |-> !scl)
      else $error("device release with scl high");
   scl_low_a: assert property ($fell(scl) |-> low_run ##[1:8] scl)
      else $error("scl low time wrong");
   scl_high_a: assert property ($rose(scl) |-> high_run)
      else $error("scl high time short");
   start_host_a: assert property ($fell(sda) && scl && $past(scl) |-> $rose(host_sda_oe))
      else $error("start not from host");
   stop_host_a: assert property ($rose(sda) && scl && $past(scl) |-> $fell(host_sda_oe))
      else $error("stop not from host");
endmodule : tw_link_monitor

// File: tb/tb_two_wire_host_port_and_boot_loader.sv
// Bench joining host and device ends over the two-wire link
`timescale 1ns/1ps
module tb_two_wire_host_port_and_boot_loader;
   logic        clock = 0, reset_n = 0, avs_read = 0, avs_write = 0, asel = 0, psel = 1, touch = 0, ee_pull = 0;
   logic        avs_waitrequest, int_out, ee_scl, ee_oe, pm_we;
   logic [7:0]  avs_address = 8'h00, pm_data, pm_d;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [11:0] pm_addr, pm_a;
   int          bad_count = 0, checked = 0, n;
   // Clock at 100 ns
   initial forever #50 clock = ~clock;
   tw_if tw_if_i ();
   tw_dev tw_dev_i (.clock(clock), .reset_n(reset_n), .bus(tw_if_i.dev_mp), .address_select_pin(asel),
      .host_port_select_pin(psel), .touch_event(touch), .int_out(int_out), .ee_scl(ee_scl),
      .ee_sda_in(~(ee_oe | ee_pull)), .ee_sda_out(), .ee_sda_oe(ee_oe), .pm_we(pm_we), .pm_addr(pm_addr),
      .pm_data(pm_data));
   tw_host tw_host_i (.clock(clock), .reset_n(reset_n), .bus(tw_if_i.host_mp), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   tw_link_monitor tw_link_monitor_i (.clock(clock), .reset_n(reset_n), .host_scl_oe(tw_if_i.host_scl_oe),
      .host_sda_oe(tw_if_i.host_sda_oe), .dev_sda_oe(tw_if_i.dev_sda_oe), .scl(tw_if_i.scl), .sda(tw_if_i.sda));
   // Last program memory write
   always @(posedge clock) if (pm_we === 1'b1) {pm_a, pm_d} <= {pm_addr, pm_data};
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic fail(input string m);
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask : fail
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checked++;
      if (g !== e) fail(m);
   endtask : chk
   // One Avalon access, held until waitrequest low
   task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr; n = 0;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 50) begin @(posedge clock); n++; end
      if (n == 50) begin fail("bus hang"); conclude(); end
      rd = avs_readdata;
      avs_write <= 0; avs_read <= 0;
      @(posedge clock);
   endtask : av
   // One framed register transfer over the link
   task automatic link(input logic rdo, input logic [7:0] r, input logic [7:0] w);
      av(1, tw_pkg::AV_REGADDR, {24'h0, r});
      av(1, tw_pkg::AV_WDATA, {24'h0, w});
      av(1, tw_pkg::AV_CMD, {30'h0, rdo, 1'b1});
      rd = 32'h1;
      for (int i = 0; i < 3000 && rd[0] !== 1'b0; i++) av(0, tw_pkg::AV_STATUS, 0);
      if (rd[0] !== 1'b0) begin fail("link hang"); conclude(); end
   endtask : link
   task automatic rchk(input logic [7:0] r, input logic [7:0] e, input string m);
      link(1, r, 8'h00);
      chk({23'h0, rd[1], rd[15:8]}, {24'h0, e}, m);
   endtask : rchk
   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1;
      repeat (8) @(posedge clock);
      rchk(tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS, tw_pkg::EE_ADDR_RST, "ee addr reset");
      link(0, tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS, 8'h51);
      rchk(tw_pkg::REG_BOOT_MEMORY_DEVICE_ADDRESS, 8'h51, "ee addr rw");
      $display("test 1 done");
      link(0, tw_pkg::REG_BOOT_CTRL, 8'h03);
      rchk(tw_pkg::REG_BOOT_STAT, 8'h06, "boot no device");
      // Memory device line held low: every bit reads 0 and is acked
      link(0, tw_pkg::REG_BOOT_LEN, 8'h01);
      ee_pull <= 1;
      link(0, tw_pkg::REG_BOOT_CTRL, 8'h03);
      repeat (2000) @(posedge clock);
      rchk(tw_pkg::REG_BOOT_STAT, 8'h02, "boot from device");
      chk({12'h0, pm_a, pm_d}, {12'h0, 12'h001, 8'h00}, "boot bytes");
      ee_pull <= 0;
      link(0, tw_pkg::REG_BOOT_CTRL, 8'h00);
      link(0, tw_pkg::REG_PM_DATA, 8'hA5);
      link(0, tw_pkg::REG_PM_DATA, 8'h3C);
      chk({12'h0, pm_a, pm_d}, {12'h0, 12'h001, 8'h3C}, "host download");
      $display("test 2 done");
      chk(int_out, 1, "int idle");
      touch <= 1;
      @(posedge clock);
      touch <= 0;
      repeat (3) @(posedge clock);
      chk(int_out, 0, "int active low");
      rchk(tw_pkg::REG_INT_STATUS, 8'h01, "int cause");
      chk(int_out, 1, "int cleared");
      link(0, tw_pkg::REG_INT_CFG, 8'h01);
      chk(int_out, 0, "int polarity");
      $display("test 3 done");
      av(1, tw_pkg::AV_SLAVE, 32'h5D);
      link(1, tw_pkg::REG_INT_CFG, 8'h00);
      chk(rd[1], 1, "wrong address acked");
      asel <= 1;
      repeat (4) @(posedge clock);
      rchk(tw_pkg::REG_INT_CFG, 8'h01, "select high");
      psel <= 0;
      repeat (4) @(posedge clock);
      link(1, tw_pkg::REG_INT_CFG, 8'h00);
      chk(rd[1], 1, "spi mode acked");
      $display("test 4 done");
      conclude();
   end
endmodule : tb_two_wire_host_port_and_boot_loader
